// [bench/tpc_chk_asserts.sv]
// Port checker for the proximity and touch controller, bound to its top
`timescale 1ns/10ps
`include "tpc_consts.vh"
module tpc_chk (
  input wire       clk,
  input wire       rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       stream_done,
  input wire       proximity_output,
  input wire       touch_output,
  input wire       charge_drive,
  input wire       dump_drive,
  input wire       measurement_duration,
  input wire       auto_tuning,
  input wire       stream_req,
  input wire       stream_two_wire,
  input wire       noise_detect_enable
);
  wire      wr_s = reg_write && reg_addr == `TPC_ADDR_STREAM_CFG;
  reg       rate;
  reg [8:0] hc;
  // Rate is snooped from writes; the bench changes it only between measurements
  always @(posedge clk) begin
    if (!rst_n) begin
      rate <= 1'b0;
    end else if (wr_s) begin
      rate <= reg_wdata[6];
    end
    hc <= charge_drive ? hc + 9'h001 : 9'h000;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_dump_run;
    (dump_drive && !charge_drive) [*8];
  endsequence
  property p_phase_excl;
    !(charge_drive && dump_drive);
  endproperty
  a_phase_excl: assert property (p_phase_excl) else $error("charge and dump high together");
  property p_dump_follows;
    $fell(charge_drive) && measurement_duration |-> s_dump_run;
  endproperty
  a_dump_follows: assert property (p_dump_follows) else $error("dump half missing after charge");
  property p_half_len;
    $fell(charge_drive) && measurement_duration |-> hc == (rate ? 9'h0FA : 9'h07A);
  endproperty
  a_half_len: assert property (p_half_len) else $error("charge half length off");
  property p_stream_quiet;
    stream_req |-> !measurement_duration;
  endproperty
  a_stream_quiet: assert property (p_stream_quiet) else $error("stream overlaps measurement");
  property p_stream_hold;
    stream_req && !stream_done |=> stream_req;
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream request dropped early");
  property p_link_follow;
    wr_s |-> ##2 stream_two_wire == $past(reg_wdata[7], 2);
  endproperty
  a_link_follow: assert property (p_link_follow) else $error("link select wrong");
  property p_noise_follow;
    wr_s |-> ##2 noise_detect_enable == ($past(reg_wdata[4], 2) && !$past(reg_wdata[7], 2));
  endproperty
  a_noise_follow: assert property (p_noise_follow) else $error("noise enable wrong");
  property p_pins_untuned;
    auto_tuning |-> proximity_output && touch_output;
  endproperty
  a_pins_untuned: assert property (p_pins_untuned) else $error("pin low before tuning done");
endmodule
bind tpc_top tpc_chk tpc_chk_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .stream_done(stream_done), .proximity_output(proximity_output), .touch_output(touch_output),
  .charge_drive(charge_drive), .dump_drive(dump_drive), .measurement_duration(measurement_duration),
  .auto_tuning(auto_tuning), .stream_req(stream_req), .stream_two_wire(stream_two_wire),
  .noise_detect_enable(noise_detect_enable)
);

// [bench/tpc_front_model.sv]
// Front end and streaming engine model facing the controller
`timescale 1ns/10ps
module tpc_front_model #(
  parameter [15:0] PULSES = 16'h0002
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       dump_drive,
  input  wire       measurement_duration,
  input  wire       stream_req,
  input  wire [7:0] done_lat,
  output reg        trip_in,
  output reg        stream_done
);
  reg        dump_q;
  reg [15:0] pulses;
  reg [7:0]  wait_cnt;
  // Trip at the end of a fixed dump half; cleared with the measurement as the reference is emptied
  always @(posedge clk) begin
    dump_q <= dump_drive;
    if (!rst_n || !measurement_duration) begin
      pulses <= 16'h0000;
      trip_in <= 1'b0;
    end else if (dump_q && !dump_drive) begin
      pulses <= pulses + 16'h0001;
      trip_in <= pulses + 16'h0001 == PULSES;
    end
  end
  // Done after a chosen wait, prompt or slow, and high for a single cycle
  always @(posedge clk) begin
    if (!rst_n || stream_done || !stream_req) begin
      stream_done <= 1'b0;
      wait_cnt <= 8'h00;
    end else if (wait_cnt == done_lat) begin
      stream_done <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule

// [bench/tpc_top_tb.sv]
// Self-checking bench for the proximity and touch controller
`timescale 1ns/10ps
`include "tpc_consts.vh"
module tpc_top_tb;
  localparam [31:0] HOLD   = 32'h000036B0;
  localparam [15:0] PULSES = 16'h0002;
  reg         clk, rst_n, reg_write, reg_read, prox_cond_in, touch_cond_in, look, rd_q, look_s, tun_exp;
  reg  [7:0]  reg_addr, reg_wdata, done_lat, v;
  wire [7:0]  reg_rdata;
  wire        trip_in, stream_done, proximity_output, touch_output, charge_drive, dump_drive;
  wire        measurement_duration, auto_tuning, stream_req, stream_two_wire, noise_detect_enable;
  wire [15:0] stream_count;
  reg  [7:0]  exp_q[$];
  integer     n_mismatch, num_checks, seed, i, cyc, t0, t1;
  tpc_top #(.BOOST_CYC(32'h258), .NORMAL_CYC(32'h2BC), .SLOW1_CYC(32'h320), .SLOW2_CYC(32'h384),
    .HOLD_CYC(HOLD), .TUNE_CYC(32'hBB8)) tpc_top_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .trip_in(trip_in), .prox_cond_in(prox_cond_in),
    .touch_cond_in(touch_cond_in), .stream_done(stream_done), .proximity_output(proximity_output),
    .touch_output(touch_output), .charge_drive(charge_drive), .dump_drive(dump_drive),
    .measurement_duration(measurement_duration), .auto_tuning(auto_tuning), .stream_req(stream_req),
    .stream_count(stream_count), .stream_two_wire(stream_two_wire), .noise_detect_enable(noise_detect_enable));
  tpc_front_model #(.PULSES(PULSES)) tpc_front_model_i (
    .clk(clk), .rst_n(rst_n), .dump_drive(dump_drive), .measurement_duration(measurement_duration),
    .stream_req(stream_req), .done_lat(done_lat), .trip_in(trip_in), .stream_done(stream_done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task check(input [7:0] seen, input [7:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  // Oldest note is matched against read data, the pin pair or the stream count
  always @(posedge clk) begin
    rd_q <= reg_read;
    if (rd_q) check(reg_rdata, exp_q.pop_front());
    if (look) check({5'h00, auto_tuning, touch_output, proximity_output}, exp_q.pop_front());
    if (look_s) begin
      check(stream_count[7:0], exp_q.pop_front());
      check(stream_count[15:8], exp_q.pop_front());
    end
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
    end
  endtask
  task pins(input [1:0] e);
    begin
      exp_q.push_back({5'h00, tun_exp, e});
      @(posedge clk);
      look <= 1'b1;
      @(posedge clk);
      look <= 1'b0;
    end
  endtask
  // Count handed to the stream engine, low byte noted first
  task strm(input [15:0] e);
    begin
      exp_q.push_back(e[7:0]);
      exp_q.push_back(e[15:8]);
      @(posedge clk);
      look_s <= 1'b1;
      @(posedge clk);
      look_s <= 1'b0;
    end
  endtask
  // Returns a few cycles after the n-th measurement end, once pins have settled
  task meas(input integer n);
    begin
      repeat (n) @(negedge measurement_duration);
      repeat (8) @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run of some 50000 cycles
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    seed = 77834;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    {rst_n, reg_write, reg_read, prox_cond_in, touch_cond_in, look, rd_q, look_s} = 8'h00;
    tun_exp = 1'b1;
    {reg_addr, reg_wdata} = 16'h0000;
    done_lat = 8'h02;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TPC_ADDR_STREAM_CFG, `TPC_CFG_RESET);
    rd(`TPC_ADDR_OUTPUT_CFG, `TPC_CFG_RESET);
    pins(2'b11);
    // Rate bit kept clear so no measurement changes speed midway
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      v[6] = 1'b0;
      wr(`TPC_ADDR_STREAM_CFG, v);
      rd(`TPC_ADDR_STREAM_CFG, v);
    end
    wr(8'hC5, 8'hFF);
    rd(8'hC5, `TPC_RDATA_NONE);
    $display("test config done");
    meas(1);
    wr(`TPC_ADDR_STREAM_CFG, 8'h64);
    wr(`TPC_ADDR_OUTPUT_CFG, 8'h20);
    meas(2);
    // A slow-rate measurement outlasts the boost interval, so the next one is already running
    rd(`TPC_ADDR_STATUS, 8'h24);
    rd(`TPC_ADDR_COUNT_LO, PULSES[7:0]);
    rd(`TPC_ADDR_COUNT_HI, PULSES[15:8]);
    strm(PULSES);
    tun_exp = 1'b0;
    pins(2'b00);
    $display("test measure done");
    done_lat <= 8'h28;
    prox_cond_in <= 1'b1;
    touch_cond_in <= 1'b1;
    meas(2);
    pins(2'b00);
    meas(1);
    pins(2'b10);
    meas(2);
    pins(2'b10);
    meas(1);
    pins(2'b11);
    prox_cond_in <= 1'b0;
    touch_cond_in <= 1'b0;
    meas(1);
    pins(2'b00);
    $display("test direct done");
    wr(`TPC_ADDR_OUTPUT_CFG, 8'h60);
    prox_cond_in <= 1'b1;
    meas(6);
    pins(2'b01);
    t0 = cyc;
    prox_cond_in <= 1'b0;
    meas(1);
    pins(2'b01);
    prox_cond_in <= 1'b1;
    meas(6);
    pins(2'b01);
    t1 = cyc;
    prox_cond_in <= 1'b0;
    while (cyc < t0 + HOLD + 300) @(posedge clk);
    pins(2'b01);
    while (cyc < t1 + HOLD + 300) @(posedge clk);
    pins(2'b00);
    $display("test latch done");
    wr(`TPC_ADDR_OUTPUT_CFG, 8'h80);
    meas(1);
    pins(2'b11);
    for (i = 0; i < 2; i = i + 1) begin
      touch_cond_in <= 1'b1;
      meas(3);
      pins({i[0], 1'b1});
      touch_cond_in <= 1'b0;
      meas(1);
      pins({i[0], 1'b1});
    end
    wr(`TPC_ADDR_OUTPUT_CFG, 8'hC0);
    rd(`TPC_ADDR_OUTPUT_CFG, 8'hC0);
    $display("test toggle done");
    tally_and_finish;
  end
endmodule

// [common/tpc_consts.vh]
// Constants for the proximity and touch output controller
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH
// Register addresses
`define TPC_ADDR_OUTPUT_CFG 8'hC4
`define TPC_ADDR_STREAM_CFG 8'hC6
`define TPC_ADDR_STATUS     8'hC8
`define TPC_ADDR_COUNT_LO   8'hCA
`define TPC_ADDR_COUNT_HI   8'hCB
`define TPC_CFG_RESET       8'h00
`define TPC_RDATA_NONE      8'h00
// Field positions in stream_sense_config
`define TPC_S_LINK      7
`define TPC_S_RATE      6
`define TPC_S_STREAM    5
`define TPC_S_NOISE     4
`define TPC_S_TARGET    3
`define TPC_S_SCOPE     2
`define TPC_S_PERIOD_HI 1
`define TPC_S_PERIOD_LO 0
// Field positions in output_config
`define TPC_O_TOUCH_FUNC 7
`define TPC_O_PROX_FUNC  6
`define TPC_O_POLARITY   5
// Field positions in the status register
`define TPC_B_PROX_EVENT  0
`define TPC_B_TOUCH_EVENT 1
`define TPC_B_TUNED       2
`define TPC_B_PROX_PIN    3
`define TPC_B_TOUCH_PIN   4
`define TPC_B_MEASURING   5
`define TPC_B_STREAMING   6
// Sample period codes
`define TPC_PER_BOOST  2'h0
`define TPC_PER_NORMAL 2'h1
`define TPC_PER_SLOW1  2'h2
`define TPC_PER_SLOW2  2'h3
// Tuning targets, 1024 and 512 counts
`define TPC_TARGET_FULL 16'h0400
`define TPC_TARGET_HALF 16'h0200
`define TPC_COUNT_MAX   16'hFFFF
// Output modes
`define TPC_MODE_DIRECT 2'h0
`define TPC_MODE_LATCH  2'h1
`define TPC_MODE_TOGGLE 2'h2
// Consecutive samples needed: 6 proximity, 3 touch
`define TPC_PROX_SAMPLES  3'h6
`define TPC_TOUCH_SAMPLES 3'h3
// Scheduler states
`define TPC_ST_WAIT   2'h0
`define TPC_ST_CHARGE 2'h1
`define TPC_ST_STREAM 2'h2
// Time base: 125 MHz clock
`define TPC_CLK_HZ    32'h07735940
`define TPC_MS_DIV    32'h3E8
`define TPC_NS_DIV    32'h3B9ACA00
`define TPC_RATE_FAST_HZ 32'h0007D000
`define TPC_RATE_SLOW_HZ 32'h0003D090
// Times in ms: 9, 128, 256, 512, hold 4000, tuning 500
`define TPC_BOOST_MS  32'h9
`define TPC_NORMAL_MS 32'h80
`define TPC_SLOW1_MS  32'h100
`define TPC_SLOW2_MS  32'h200
`define TPC_HOLD_MS   32'hFA0
`define TPC_TUNE_MS   32'h1F4
// Minimum asserted time in ns, arbitrary default 1000
`define TPC_MIN_ASSERT_NS 32'h3E8
`endif

// [rtl/tpc_debounce.v]
// Consecutive-sample qualifier for one detection condition
`timescale 1ns/10ps
`include "tpc_consts.vh"
module tpc_debounce #(
  parameter [2:0] SAMPLES = 3'h1
) (
  input  wire clk,
  input  wire rst_n,
  input  wire clear,
  input  wire sample,
  input  wire cond,
  output reg  event_out
);
  reg [2:0] run;

  // Count the run of qualifying samples, saturating at the target
  always @(posedge clk) begin
    if (!rst_n || clear) begin
      run       <= 3'h0;
      event_out <= 1'b0;
    end else if (sample) begin
      if (cond) begin
        if (run != SAMPLES)
          run <= run + 3'h1;
        event_out <= (run + 3'h1 >= SAMPLES);
      end else begin
        run       <= 3'h0;
        event_out <= 1'b0;
      end
    end
  end
endmodule

// [rtl/tpc_out_stage.v]
// One output pin: direct, latch or toggle, polarity and minimum time
`timescale 1ns/10ps
`include "tpc_consts.vh"
module tpc_out_stage #(
  parameter [31:0] HOLD_CYC = 32'h1,
  parameter [31:0] MIN_CYC  = 32'h1
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] mode,
  input  wire       active_high,
  input  wire       tuned,
  input  wire       event_in,
  output reg        pin
);
  reg        ev_d;
  reg [31:0] hold;
  reg        tog;
  reg        asserted;
  reg [31:0] min_left;
  wire       rise = event_in & ~ev_d;
  wire       want = (mode == `TPC_MODE_LATCH)  ? (event_in | (hold != 32'h0)) :
                    (mode == `TPC_MODE_TOGGLE) ? tog : event_in;

  // Hold timer runs only in latch mode; a new onset restarts it
  always @(posedge clk) begin
    if (!rst_n || mode != `TPC_MODE_LATCH)
      hold <= 32'h0;
    else if (rise)
      hold <= HOLD_CYC;
    else if (hold != 32'h0)
      hold <= hold - 32'h1;
  end

  // Edge memory and toggle state
  always @(posedge clk) begin
    if (!rst_n) begin
      ev_d <= 1'b0;
      tog  <= 1'b0;
    end else begin
      ev_d <= event_in;
      if (rise && mode == `TPC_MODE_TOGGLE)
        tog <= ~tog;
    end
  end

  // Release only after the minimum asserted time has run out
  always @(posedge clk) begin
    if (!rst_n) begin
      asserted <= 1'b0;
      min_left <= 32'h0;
    end else if (want && !asserted) begin
      asserted <= 1'b1;
      min_left <= MIN_CYC - 32'h1;
    end else if (asserted && min_left != 32'h0) begin
      min_left <= min_left - 32'h1;
    end else if (!want && asserted) begin
      asserted <= 1'b0;
    end
  end

  // Inactive-high while tuning, then polarity-mapped push-pull level
  always @(posedge clk) begin
    if (!rst_n || !tuned)
      pin <= 1'b1;
    else
      pin <= active_high ? asserted : ~asserted;
  end
endmodule

// [rtl/tpc_top.v]
// Proximity and touch controller: configuration, charge scheduling, outputs
`timescale 1ns/10ps
`include "tpc_consts.vh"
// How it works
// - stream config bit 7 picks one-wire (0) or two-wire I2C (1) streaming.
// - bit 6 sets charge pulse rate, 0 is 512kHz, 1 is 250kHz.
// - bit 5 enables result streaming when set.
// - bit 4 enables noise detection, honoured only with the one-wire link.
// - bit 3 sets tuning target, 0 is 1024 counts, 1 is 512.
// - bit 2 picks full (0) or partial (1) tuning.
// - bits 1-0 set sample period 9, 128, 256 or 512 ms.
// - measurement pulses charge and dump until trip; pulse total is the count.
// - one measurement per interval; streaming finishes before the next one.
// - all configuration bits reset to zero, the default behaviour.
// - an asserted output holds at least the minimum high or low time.
// - proximity result drives proximity output, touch result drives touch output.
// - output config bit 5 sets polarity, 0 active low, 1 active high.
// - both outputs are push-pull, always driven both ways.
// - outputs stay high from reset until tuning completes, at most 500ms.
// - output config bit 6 picks direct or latch for proximity, bit 7 direct or toggle for touch.
// - direct mode follows the event exactly.
// - latch mode holds the output asserted for 4 seconds after onset.
// - latch mode keeps asserted while the event outlasts the hold interval.
// - a new event during the hold restarts the 4 second timer.
// - toggle mode inverts the output once per event onset.
// - proximity needs 6 consecutive qualifying samples.
// - touch needs 3 consecutive qualifying samples.
module tpc_top #(
  parameter [31:0] BOOST_CYC  = `TPC_BOOST_MS * (`TPC_CLK_HZ / `TPC_MS_DIV),
  parameter [31:0] NORMAL_CYC = `TPC_NORMAL_MS * (`TPC_CLK_HZ / `TPC_MS_DIV),
  parameter [31:0] SLOW1_CYC  = `TPC_SLOW1_MS * (`TPC_CLK_HZ / `TPC_MS_DIV),
  parameter [31:0] SLOW2_CYC  = `TPC_SLOW2_MS * (`TPC_CLK_HZ / `TPC_MS_DIV),
  parameter [31:0] HOLD_CYC   = `TPC_HOLD_MS * (`TPC_CLK_HZ / `TPC_MS_DIV),
  parameter [31:0] TUNE_CYC   = `TPC_TUNE_MS * (`TPC_CLK_HZ / `TPC_MS_DIV),
  parameter [31:0] MIN_ASSERT_NS = `TPC_MIN_ASSERT_NS
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire        trip_in,
  input  wire        prox_cond_in,
  input  wire        touch_cond_in,
  input  wire        stream_done,
  output wire        proximity_output,
  output wire        touch_output,
  output reg         charge_drive,
  output reg         dump_drive,
  output reg         measurement_duration,
  output reg         auto_tuning,
  output reg         stream_req,
  output reg  [15:0] stream_count,
  output reg         stream_two_wire,
  output reg         noise_detect_enable
);
  // Half pulse periods; rounding down keeps the rate at or above nominal
  localparam [31:0] HALF_FAST_RAW = `TPC_CLK_HZ / (`TPC_RATE_FAST_HZ * 32'h2);
  localparam [31:0] HALF_SLOW_RAW = `TPC_CLK_HZ / (`TPC_RATE_SLOW_HZ * 32'h2);
  localparam [15:0] HALF_FAST     = HALF_FAST_RAW[15:0];
  localparam [15:0] HALF_SLOW     = HALF_SLOW_RAW[15:0];
  // Minimum asserted time rounded up to whole cycles, never below one
  localparam [31:0] MIN_RAW = (MIN_ASSERT_NS * (`TPC_CLK_HZ / `TPC_MS_DIV) + `TPC_NS_DIV / `TPC_MS_DIV - 32'h1)
                              / (`TPC_NS_DIV / `TPC_MS_DIV);
  localparam [31:0] MIN_CYC = (MIN_RAW == 32'h0) ? 32'h1 : MIN_RAW;

  reg  [7:0]  output_config;
  reg  [7:0]  stream_sense_config;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [31:0] ivl_cnt;
  reg  [15:0] phase_cnt;
  reg         phase;
  reg  [15:0] pulse_cnt;
  reg  [15:0] count_value;
  reg         meas_done;
  reg         tuned;
  reg  [31:0] tune_cnt;
  reg  [2:0]  trip_sync;
  reg  [1:0]  prox_sync;
  reg  [1:0]  touch_sync;
  reg  [31:0] period_cyc;
  reg  [7:0]  next_rdata;
  wire        prox_event;
  wire        touch_event;
  wire        prox_pin;
  wire        touch_pin;
  wire        pulse_rate_select    = stream_sense_config[`TPC_S_RATE];
  wire        stream_enable        = stream_sense_config[`TPC_S_STREAM];
  wire [1:0]  sample_period_select = stream_sense_config[`TPC_S_PERIOD_HI:`TPC_S_PERIOD_LO];
  wire [15:0] half_cyc   = pulse_rate_select ? HALF_SLOW : HALF_FAST;
  wire [15:0] target     = stream_sense_config[`TPC_S_TARGET] ? `TPC_TARGET_HALF : `TPC_TARGET_FULL;
  wire        partial    = stream_sense_config[`TPC_S_SCOPE];
  wire        ivl_up     = (ivl_cnt >= period_cyc - 32'h1);
  wire        half_end   = (phase_cnt == half_cyc - 16'h1);
  // Phase after this edge; the strobes follow it so that the first half
  // of a measurement is no longer than the others
  wire        next_phase = (state == `TPC_ST_CHARGE) && (phase ^ half_end);
  wire        trip_seen  = trip_sync[2];
  wire        meas_end   = (state == `TPC_ST_CHARGE) && (trip_seen || pulse_cnt == `TPC_COUNT_MAX);
  wire [1:0]  prox_mode  = output_config[`TPC_O_PROX_FUNC] ? `TPC_MODE_LATCH : `TPC_MODE_DIRECT;
  wire [1:0]  touch_mode = output_config[`TPC_O_TOUCH_FUNC] ? `TPC_MODE_TOGGLE : `TPC_MODE_DIRECT;

  // Configuration registers, written over the plain port
  always @(posedge clk) begin
    if (!rst_n) begin
      output_config       <= `TPC_CFG_RESET;
      stream_sense_config <= `TPC_CFG_RESET;
    end else if (reg_write) begin
      if (reg_addr == `TPC_ADDR_OUTPUT_CFG)
        output_config <= reg_wdata;
      if (reg_addr == `TPC_ADDR_STREAM_CFG)
        stream_sense_config <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses answer zero
  always @* begin
    next_rdata = `TPC_RDATA_NONE;
    case (reg_addr)
      `TPC_ADDR_OUTPUT_CFG: next_rdata = output_config;
      `TPC_ADDR_STREAM_CFG: next_rdata = stream_sense_config;
      `TPC_ADDR_COUNT_LO:   next_rdata = count_value[7:0];
      `TPC_ADDR_COUNT_HI:   next_rdata = count_value[15:8];
      `TPC_ADDR_STATUS: begin
        next_rdata[`TPC_B_PROX_EVENT]  = prox_event;
        next_rdata[`TPC_B_TOUCH_EVENT] = touch_event;
        next_rdata[`TPC_B_TUNED]       = tuned;
        next_rdata[`TPC_B_PROX_PIN]    = prox_pin;
        next_rdata[`TPC_B_TOUCH_PIN]   = touch_pin;
        next_rdata[`TPC_B_MEASURING]   = (state == `TPC_ST_CHARGE);
        next_rdata[`TPC_B_STREAMING]   = stream_req;
      end
      default: next_rdata = `TPC_RDATA_NONE;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n)
      reg_rdata <= `TPC_RDATA_NONE;
    else
      reg_rdata <= reg_read ? next_rdata : `TPC_RDATA_NONE;
  end

  // Three-stage synchroniser for trip, two-stage for the condition pins
  always @(posedge clk) begin
    if (!rst_n) begin
      trip_sync  <= 3'h0;
      prox_sync  <= 2'h0;
      touch_sync <= 2'h0;
    end else begin
      trip_sync  <= {trip_sync[1:0], trip_in};
      prox_sync  <= {prox_sync[0], prox_cond_in};
      touch_sync <= {touch_sync[0], touch_cond_in};
    end
  end

  // Sample period from the selected power mode
  always @* begin
    case (sample_period_select)
      `TPC_PER_BOOST:  period_cyc = BOOST_CYC;
      `TPC_PER_NORMAL: period_cyc = NORMAL_CYC;
      `TPC_PER_SLOW1:  period_cyc = SLOW1_CYC;
      `TPC_PER_SLOW2:  period_cyc = SLOW2_CYC;
      default:         period_cyc = BOOST_CYC;
    endcase
  end

  // Scheduler: wait for the interval, charge, then optionally stream
  always @* begin
    next_state = state;
    case (state)
      `TPC_ST_WAIT:
        if (ivl_up)
          next_state = `TPC_ST_CHARGE;
      `TPC_ST_CHARGE:
        if (meas_end)
          next_state = stream_enable ? `TPC_ST_STREAM : `TPC_ST_WAIT;
      `TPC_ST_STREAM:
        if (stream_done)
          next_state = `TPC_ST_WAIT;
      default:
        next_state = `TPC_ST_WAIT;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n)
      state <= `TPC_ST_WAIT;
    else
      state <= next_state;
  end

  // Interval counter restarts at each measurement start; it parks at
  // expiry so a slow stream delays the next start instead of overlapping
  always @(posedge clk) begin
    if (!rst_n)
      ivl_cnt <= 32'h0;
    else if (state == `TPC_ST_WAIT && ivl_up)
      ivl_cnt <= 32'h0;
    else if (!ivl_up)
      ivl_cnt <= ivl_cnt + 32'h1;
  end

  // Charge and dump phases at the pulse rate; each completed dump counts
  always @(posedge clk) begin
    if (!rst_n || state != `TPC_ST_CHARGE) begin
      phase_cnt <= 16'h0;
      phase     <= 1'b0;
      pulse_cnt <= 16'h0;
    end else if (half_end) begin
      phase_cnt <= 16'h0;
      phase     <= ~phase;
      if (phase)
        pulse_cnt <= pulse_cnt + 16'h1;
    end else begin
      phase_cnt <= phase_cnt + 16'h1;
    end
  end

  // Non-overlapping drive strobes toward the front end
  always @(posedge clk) begin
    if (!rst_n) begin
      charge_drive         <= 1'b0;
      dump_drive           <= 1'b0;
      measurement_duration <= 1'b0;
    end else begin
      charge_drive         <= (next_state == `TPC_ST_CHARGE) && !next_phase && !meas_end;
      dump_drive           <= (next_state == `TPC_ST_CHARGE) && next_phase && !meas_end;
      measurement_duration <= (next_state == `TPC_ST_CHARGE);
    end
  end

  // Capture the count at trip; a saturated count also ends the cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      count_value <= 16'h0;
      meas_done   <= 1'b0;
    end else begin
      meas_done <= meas_end;
      if (meas_end)
        count_value <= pulse_cnt;
    end
  end

  // Streaming handshake: request after the measurement, held until done
  always @(posedge clk) begin
    if (!rst_n) begin
      stream_req   <= 1'b0;
      stream_count <= 16'h0;
    end else if (meas_end && stream_enable) begin
      stream_req   <= 1'b1;
      stream_count <= pulse_cnt;
    end else if (state == `TPC_ST_STREAM && stream_done) begin
      stream_req <= 1'b0;
    end
  end

  // Link type and noise detect, the latter only valid on one wire
  always @(posedge clk) begin
    if (!rst_n) begin
      stream_two_wire     <= 1'b0;
      noise_detect_enable <= 1'b0;
    end else begin
      stream_two_wire     <= stream_sense_config[`TPC_S_LINK];
      noise_detect_enable <= stream_sense_config[`TPC_S_NOISE] && !stream_sense_config[`TPC_S_LINK];
    end
  end

  // Tuning: partial finishes on the first count, full on reaching the
  // target; the timeout stops a heavy load from blocking the outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      tuned       <= 1'b0;
      tune_cnt    <= 32'h0;
      auto_tuning <= 1'b1;
    end else if (!tuned) begin
      tune_cnt <= tune_cnt + 32'h1;
      if ((meas_done && (partial || count_value >= target)) || tune_cnt >= TUNE_CYC - 32'h1) begin
        tuned       <= 1'b1;
        auto_tuning <= 1'b0;
      end
    end
  end

  // Proximity needs a longer run than touch to reject slow drift
  tpc_debounce #(
    .SAMPLES (`TPC_PROX_SAMPLES)
  ) u_prox_deb (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (!tuned),
    .sample    (meas_done),
    .cond      (prox_sync[1]),
    .event_out (prox_event)
  );

  tpc_debounce #(
    .SAMPLES (`TPC_TOUCH_SAMPLES)
  ) u_touch_deb (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (!tuned),
    .sample    (meas_done),
    .cond      (touch_sync[1]),
    .event_out (touch_event)
  );

  // Fixed assignment: proximity stage feeds its pin, touch stage its own
  tpc_out_stage #(
    .HOLD_CYC (HOLD_CYC),
    .MIN_CYC  (MIN_CYC)
  ) u_prox_out (
    .clk         (clk),
    .rst_n       (rst_n),
    .mode        (prox_mode),
    .active_high (output_config[`TPC_O_POLARITY]),
    .tuned       (tuned),
    .event_in    (prox_event),
    .pin         (prox_pin)
  );

  tpc_out_stage #(
    .HOLD_CYC (HOLD_CYC),
    .MIN_CYC  (MIN_CYC)
  ) u_touch_out (
    .clk         (clk),
    .rst_n       (rst_n),
    .mode        (touch_mode),
    .active_high (output_config[`TPC_O_POLARITY]),
    .tuned       (tuned),
    .event_in    (touch_event),
    .pin         (touch_pin)
  );

  // Pins are the stage flip-flops, driven push-pull at all times
  assign proximity_output = prox_pin;
  assign touch_output     = touch_pin;
endmodule
